/* File: csa_defs.svh */
`ifndef CSA_DEFS_SVH
`define CSA_DEFS_SVH
// Operation
// R1: Software sets the serial enable bit before writing the shift register to start.
// R2: After eight bits the shifter stops and sets the transfer-done flag.
// R3: Automatic mode sends the programmed byte count, up to 32, from the buffer.
// R4: Automatic mode with receive enabled stores each received byte in the buffer.
// R5: Strobe pulses after each byte; peripheral holds busy while it cannot accept data.
// R6: Mode register resets to zero; enable low stops shifting and clears bit counter.
// R7: Automatic-mode select picks plain or buffer-driven three-wire operation.
// R8: Disabled clock pin is a port or driven high; enabled it outputs the clock.
// R9: Clock source field picks external pin or system clock divided 16, 32, 64.
// R10: Software clears strobe and busy enables when the external clock is used.
// R11: While disabled, all serial pins are left to general-purpose port use; the code drives the clock pin high when the idle-high bit is set.
// R12: Reset clears the whole automatic-transfer control register.
// R13: Active status sets on shift register write and clears at sequence end.
// R14: Error status sets on a detected error and clears on shift register write.
// R15: Error checking needs both error-check enable and busy-input enable set.
// R16: Active and error status bits are read-only; writes leave them unchanged.
// R17: With busy-input enable clear, the busy pin is ignored by the shifter.
// R18: With receive enable clear, the serial input is not stored to the buffer.
// R19: Software polls the active status bit to see automatic completion.
// R20: Busy polarity bit selects active-high busy at 0, active-low at 1.
// R21: Bit-order select sends the most significant bit first at 0, least at 1.
// R22: Repeat select gives one sequence at 0, endless repetition at 1.

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define CSA_IDX_MODE      16'hFF68
`define CSA_IDX_SHIFT     16'hFF69
`define CSA_IDX_AUTO      16'hFF6A
`define CSA_IDX_COUNT     16'hFF6C
`define CSA_IDX_STATUS    16'hFF6D
`define CSA_IDX_BUF_BASE  16'hFF80
`define CSA_BUF_WIN       11'h7FC

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define CSA_M_EN          7
`define CSA_M_LSB         6
`define CSA_M_AUTO        5
`define CSA_M_IDLEHI      4
`define CSA_A_RE          7
`define CSA_A_RPT         6
`define CSA_A_ERROR_CHECK_ENABLE        5
`define CSA_A_ERR         4
`define CSA_A_TRF         3
`define CSA_A_STROBE_OUTPUT_ENABLE        2
`define CSA_A_BUSYEN      1
`define CSA_A_BUSYPOL     0
`define CSA_MODE_WMASK    8'hF3
`define CSA_AUTO_WMASK    8'hE7
`define CSA_RST_BYTE      8'h00

// ****************************************************************
// Timing: serial clock divisors and their half periods in pclk cycles.
// ****************************************************************
`define CSA_DIV_A         16
`define CSA_DIV_B         32
`define CSA_DIV_C         64
`define CSA_HALF_A        6'(`CSA_DIV_A / 2)
`define CSA_HALF_B        6'(`CSA_DIV_B / 2)
`define CSA_HALF_C        6'(`CSA_DIV_C / 2)
`define CSA_BITS          4'd8
`define CSA_BUF_DEPTH     32
`endif

/* File: csa_pkg.sv */
package csa_pkg;
	// Serial engine states.
	typedef enum logic [2:0] {
		CSA_IDLE,
		CSA_SHIFT,
		CSA_STROBE,
		CSA_WAIT,
		CSA_NEXT
	} csa_state_t;
endpackage : csa_pkg

/* File: csa_top.sv */
`include "csa_defs.svh"
module csa_top #(
	parameter int DEPTH = `CSA_BUF_DEPTH
) (
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [17:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial clock pin.
	input  wire logic        serial_clock_pin_in,
	output logic             serial_clock_pin_out,
	output logic             serial_clock_pin_oe_n,
	// Serial data pins.
	input  wire logic        serial_in_pin,
	output logic             serial_out_pin,
	output logic             serial_out_pin_oe_n,
	// Handshake pins.
	output logic             handshake_strobe_pin,
	output logic             handshake_strobe_pin_oe_n,
	input  wire logic        busy_pin,
	// Transfer-done request flag.
	output logic             transfer_done_irq_flag
);
	// ****************************************************************
	// Declarations.
	// ****************************************************************
	logic [7:0]          mode;
	logic [7:0]          auto_ctl;
	logic                active_flag;
	logic                error_flag;
	logic                done_flag;
	logic [4:0]          count;
	logic [7:0]          sreg;
	logic [7:0]          buffer [DEPTH];
	logic [4:0]          ptr;
	logic [3:0]          bit_cnt;
	logic [5:0]          half_cnt;
	logic                sck_int;
	logic                sck_prev;
	logic                so_bit;
	logic                stb;
	csa_pkg::csa_state_t state;
	logic                acc;
	logic                wr;
	logic                hit_mode;
	logic                hit_shift;
	logic                hit_auto;
	logic                hit_count;
	logic                hit_status;
	logic                hit_buf;
	logic                start;
	logic                ext_clk;
	logic                tick;
	logic [5:0]          half;
	logic                fall_ev;
	logic                rise_ev;
	logic                byte_end;
	logic                busy_act;
	logic [7:0]          rx_byte;
	logic [7:0]          next_load;

	// Reverses bit order between the bus view and the shift order.
	function automatic logic [7:0] rev8(input logic [7:0] d, input logic flip);
		logic [7:0] r;
		r = d;
		for (int i = 0; i < 8; i++) begin
			if (flip) begin
				r[i] = d[7 - i];
			end
		end
		return r;
	endfunction : rev8

	// ****************************************************************
	// Bus decode.
	// ****************************************************************
	assign acc        = psel & penable & pready;
	assign wr         = acc & pwrite;
	assign hit_mode   = paddr == {`CSA_IDX_MODE, 2'b00};
	assign hit_shift  = paddr == {`CSA_IDX_SHIFT, 2'b00};
	assign hit_auto   = paddr == {`CSA_IDX_AUTO, 2'b00};
	assign hit_count  = paddr == {`CSA_IDX_COUNT, 2'b00};
	assign hit_status = paddr == {`CSA_IDX_STATUS, 2'b00};
	assign hit_buf    = paddr[17:7] == `CSA_BUF_WIN;

	// Start needs the enable already set and an idle shifter.
	assign start = wr & hit_shift & mode[`CSA_M_EN] & (state == csa_pkg::CSA_IDLE); // R1

	// Clock source choice and edge events.
	assign ext_clk = mode[1:0] == 2'b00; // R9
	always_comb begin
		unique case (mode[1:0])
			2'b01:   half = `CSA_HALF_A; // R9
			2'b10:   half = `CSA_HALF_B; // R9
			default: half = `CSA_HALF_C; // R9
		endcase
	end
	assign tick     = (state == csa_pkg::CSA_SHIFT || state == csa_pkg::CSA_STROBE) && half_cnt == 6'h00;
	assign fall_ev  = (state == csa_pkg::CSA_SHIFT) &&
		(ext_clk ? (sck_prev & ~serial_clock_pin_in) : (tick & sck_int));
	assign rise_ev  = (state == csa_pkg::CSA_SHIFT) &&
		(ext_clk ? (~sck_prev & serial_clock_pin_in) : (tick & ~sck_int));
	assign byte_end = rise_ev && bit_cnt == `CSA_BITS - 4'd1; // R2
	assign rx_byte  = {sreg[6:0], serial_in_pin};
	// Busy only counts when enabled, with the selected polarity.
	assign busy_act = auto_ctl[`CSA_A_BUSYEN] & (busy_pin ^ auto_ctl[`CSA_A_BUSYPOL]); // R17 R20
	assign next_load = rev8(buffer[ptr == count ? 5'd0 : ptr + 5'd1], mode[`CSA_M_LSB]); // R21

	// ****************************************************************
	// APB answer: one wait state, registered data and error.
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready &
				~(hit_mode | hit_shift | hit_auto | hit_count | hit_status | hit_buf);
			if (hit_mode) begin
				prdata <= {24'h00_0000, mode};
			end else if (hit_shift) begin
				prdata <= {24'h00_0000, rev8(sreg, mode[`CSA_M_LSB])}; // R21
			end else if (hit_auto) begin
				prdata <= {24'h00_0000, auto_ctl[7:5], error_flag, active_flag, auto_ctl[2:0]};
			end else if (hit_count) begin
				prdata <= {27'h000_0000, count};
			end else if (hit_status) begin
				prdata <= {31'h0000_0000, done_flag};
			end else if (hit_buf) begin
				prdata <= {24'h00_0000, buffer[paddr[6:2]]};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	// Control registers, writable bits only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode     <= `CSA_RST_BYTE; // R6
			auto_ctl <= `CSA_RST_BYTE; // R12
			count    <= 5'h00;
		end else begin
			if (wr && hit_mode) begin
				mode <= pwdata[7:0] & `CSA_MODE_WMASK; // R7 R8
			end
			if (wr && hit_auto) begin
				auto_ctl <= pwdata[7:0] & `CSA_AUTO_WMASK; // R16
			end
			if (wr && hit_count) begin
				count <= pwdata[4:0];
			end
		end
	end

	// Done flag: set by hardware, cleared by writing one; set wins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_flag <= 1'b0;
		end else if ((byte_end && !mode[`CSA_M_AUTO]) || (state == csa_pkg::CSA_NEXT && ptr == count &&
			!auto_ctl[`CSA_A_RPT]) || (rise_ev && mode[`CSA_M_AUTO] && auto_ctl[`CSA_A_ERROR_CHECK_ENABLE] && busy_act)) begin
			done_flag <= 1'b1; // R2
		end else if (wr && hit_status && pwdata[0]) begin
			done_flag <= 1'b0;
		end
	end

	// Active and error status; only the shifter, start and a cleared enable move them.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_flag <= 1'b0;
			error_flag  <= 1'b0;
		end else if (start) begin
			active_flag <= mode[`CSA_M_AUTO]; // R13
			error_flag  <= 1'b0; // R14
		end else if (rise_ev && mode[`CSA_M_AUTO] && auto_ctl[`CSA_A_ERROR_CHECK_ENABLE] && busy_act) begin
			active_flag <= 1'b0;
			error_flag  <= 1'b1; // R14 R15
		end else if (state == csa_pkg::CSA_NEXT && ptr == count && !auto_ctl[`CSA_A_RPT]) begin
			active_flag <= 1'b0; // R13 R22
		end else if (!mode[`CSA_M_EN]) begin
			active_flag <= 1'b0;
		end
	end

	// ****************************************************************
	// Serial engine.
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= csa_pkg::CSA_IDLE;
		end else if (!mode[`CSA_M_EN]) begin
			state <= csa_pkg::CSA_IDLE; // R6
		end else begin
			unique case (state)
				csa_pkg::CSA_IDLE: begin
					if (start) begin
						state <= csa_pkg::CSA_SHIFT;
					end
				end
				csa_pkg::CSA_SHIFT: begin
					if (rise_ev && mode[`CSA_M_AUTO] && auto_ctl[`CSA_A_ERROR_CHECK_ENABLE] && busy_act) begin
						state <= csa_pkg::CSA_IDLE; // R15
					end else if (byte_end) begin
						if (!mode[`CSA_M_AUTO]) begin
							state <= csa_pkg::CSA_IDLE; // R2 R7
						end else if (auto_ctl[`CSA_A_STROBE_OUTPUT_ENABLE]) begin
							state <= csa_pkg::CSA_STROBE; // R5
						end else begin
							state <= csa_pkg::CSA_NEXT;
						end
					end
				end
				csa_pkg::CSA_STROBE: begin
					if (tick) begin
						state <= auto_ctl[`CSA_A_BUSYEN] ? csa_pkg::CSA_WAIT : csa_pkg::CSA_NEXT;
					end
				end
				csa_pkg::CSA_WAIT: begin
					if (!busy_act) begin
						state <= csa_pkg::CSA_NEXT; // R5
					end
				end
				csa_pkg::CSA_NEXT: begin
					if (ptr == count && !auto_ctl[`CSA_A_RPT]) begin
						state <= csa_pkg::CSA_IDLE; // R3
					end else begin
						state <= csa_pkg::CSA_SHIFT; // R3 R22
					end
				end
			endcase
		end
	end

	// Half-period timer and internal serial clock, idle high.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_cnt <= 6'h00;
			sck_int  <= 1'b1;
			sck_prev <= 1'b1;
		end else begin
			sck_prev <= serial_clock_pin_in;
			if (state == csa_pkg::CSA_IDLE || state == csa_pkg::CSA_NEXT || state == csa_pkg::CSA_WAIT) begin
				half_cnt <= half - 6'h01;
				sck_int  <= 1'b1;
			end else if (half_cnt == 6'h00) begin
				half_cnt <= half - 6'h01;
				sck_int  <= (state == csa_pkg::CSA_SHIFT) ? ~sck_int : 1'b1; // R9
			end else begin
				half_cnt <= half_cnt - 6'h01;
			end
		end
	end

	// Bit counter, cleared whenever the port is disabled.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_cnt <= 4'h0;
		end else if (!mode[`CSA_M_EN] || state != csa_pkg::CSA_SHIFT) begin
			bit_cnt <= 4'h0; // R6
		end else if (rise_ev) begin
			bit_cnt <= byte_end ? 4'h0 : bit_cnt + 4'h1;
		end
	end

	// Shift register: out on falling edge, in on rising edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sreg   <= 8'h00;
			so_bit <= 1'b0;
		end else if (start) begin
			sreg   <= rev8(mode[`CSA_M_AUTO] ? buffer[0] : pwdata[7:0], mode[`CSA_M_LSB]); // R21 R3
			so_bit <= 1'b0;
		end else if (fall_ev) begin
			so_bit <= sreg[7];
		end else if (rise_ev) begin
			sreg <= rx_byte;
		end else if (state == csa_pkg::CSA_NEXT) begin
			sreg <= next_load; // R3
		end
	end

	// Buffer pointer over the programmed byte count.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr <= 5'h00;
		end else if (start) begin
			ptr <= 5'h00;
		end else if (state == csa_pkg::CSA_NEXT) begin
			ptr <= (ptr == count) ? 5'h00 : ptr + 5'h01; // R3 R22
		end
	end

	// Buffer: bus writes, and received bytes when receive is enabled.
	always_ff @(posedge pclk) begin
		if (byte_end && mode[`CSA_M_AUTO] && auto_ctl[`CSA_A_RE]) begin
			buffer[ptr] <= rev8(rx_byte, mode[`CSA_M_LSB]); // R4 R18
		end else if (wr && hit_buf) begin
			buffer[paddr[6:2]] <= pwdata[7:0];
		end
	end

	// Strobe: high for one half period less one pclk cycle after each automatic byte.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stb <= 1'b0;
		end else begin
			stb <= state == csa_pkg::CSA_STROBE && !tick; // R5
		end
	end

	// ****************************************************************
	// Pin drivers, all registered.
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_clock_pin_out      <= 1'b1;
			serial_clock_pin_oe_n     <= 1'b1;
			serial_out_pin            <= 1'b0;
			serial_out_pin_oe_n       <= 1'b1;
			handshake_strobe_pin      <= 1'b0;
			handshake_strobe_pin_oe_n <= 1'b1;
			transfer_done_irq_flag    <= 1'b0;
		end else begin
			serial_clock_pin_out      <= mode[`CSA_M_EN] ? (ext_clk | sck_int) : 1'b1; // R8
			serial_clock_pin_oe_n     <= mode[`CSA_M_EN] ? ext_clk : ~mode[`CSA_M_IDLEHI]; // R8 R11
			serial_out_pin            <= so_bit;
			serial_out_pin_oe_n       <= ~mode[`CSA_M_EN]; // R11
			handshake_strobe_pin      <= stb; // R5
			handshake_strobe_pin_oe_n <= ~(mode[`CSA_M_EN] & auto_ctl[`CSA_A_STROBE_OUTPUT_ENABLE]); // R11
			transfer_done_irq_flag    <= done_flag;
		end
	end

	// ****************************************************************
	// Checks.
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence plain_byte_s;
		byte_end && !mode[`CSA_M_AUTO];
	endsequence
	sequence auto_start_s;
		start && mode[`CSA_M_AUTO];
	endsequence

	done_on_byte_a: assert property (plain_byte_s |=> done_flag ##1 transfer_done_irq_flag) // R2
		else $error("done flag not raised after plain byte");
	active_on_start_a: assert property (auto_start_s |=> active_flag && state == csa_pkg::CSA_SHIFT) // R13
		else $error("active status not set by start");
	error_clear_a: assert property (start |=> !error_flag) // R14
		else $error("error status not cleared by start");
	no_start_dis_a: assert property (wr && hit_shift && !mode[`CSA_M_EN] |=> state == csa_pkg::CSA_IDLE) // R1
		else $error("transfer started while disabled");
	counter_held_a: assert property (!mode[`CSA_M_EN] |=> bit_cnt == 4'h0 && state == csa_pkg::CSA_IDLE) // R6
		else $error("bit counter runs while disabled");
	status_ro_a: assert property (wr && hit_auto && state == csa_pkg::CSA_IDLE && !start
		|=> $stable(active_flag) && $stable(error_flag)) // R16
		else $error("status bits changed by bus write");
	strobe_pulse_a: assert property ($rose(stb) |=> handshake_strobe_pin) // R5
		else $error("strobe pin does not follow strobe");
	busy_hold_a: assert property (state == csa_pkg::CSA_WAIT && busy_act && mode[`CSA_M_EN]
		|=> state == csa_pkg::CSA_WAIT) // R5
		else $error("shifter resumed while busy");
	clock_idle_a: assert property (!mode[`CSA_M_EN] && mode[`CSA_M_IDLEHI] |=> serial_clock_pin_out
		&& !serial_clock_pin_oe_n) // R8
		else $error("disabled clock pin not held high");
	ptr_bound_a: assert property (mode[`CSA_M_AUTO] |-> ptr <= count) // R3
		else $error("buffer pointer beyond count");
	err_check_a: assert property (!auto_ctl[`CSA_A_BUSYEN] && !start |=> !$rose(error_flag)) // R15
		else $error("error raised without busy enable");
endmodule : csa_top

/* File: csa_peer.sv */
module csa_peer (
	// Clock.
	input  wire logic pclk,
	// Serial link from the block.
	input  wire logic sck,
	input  wire logic sdo,
	input  wire logic stb,
	// Controls set by the bench.
	input  wire logic jam,
	input  wire logic pol,
	// Replies to the block.
	output logic      sdi,
	output logic      busy
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// Peripheral that replies with a counting byte stream and logs what it gets.
	// ****************************************************************
	logic [7:0] tx   = 8'h00;
	logic [7:0] rxs  = 8'h00;
	logic [7:0] rxq [0:31];
	int         nrx  = 0, nbit = 0, nstb = 0, hold = 0;
	int         bcnt = 0, lo = 0, half = 0, gap = 0, since = 0;
	initial sdi = 1'b0;

	// The next reply bit goes out on each falling clock edge.
	always @(negedge sck) begin
		sdi <= tx[3'(7 - nbit)];
		gap <= since;
	end

	// A bit is taken on each rising edge; every full byte is logged.
	always @(posedge sck) begin
		rxs = {rxs[6:0], sdo};
		nbit = nbit + 1;
		if (nbit == 8) begin
			rxq[nrx[4:0]] <= rxs;
			nrx = nrx + 1;
			nbit = 0;
			tx <= tx + 8'h01;
		end
	end

	// Measures the low half of the clock and the time since a strobe.
	always @(posedge pclk) begin
		if (!sck) begin
			lo <= lo + 1;
		end else begin
			if (lo != 0) half <= lo;
			lo <= 0;
		end
		since <= since + 1;
		if (bcnt != 0) bcnt <= bcnt - 1;
	end

	// Each strobe makes the peripheral busy for the hold time.
	always @(posedge stb) begin
		bcnt = hold;
		since = 0;
		nstb = nstb + 1;
	end

	// Busy shows at the level that the polarity input selects.
	assign busy = ((bcnt != 0) | jam) ^ pol;
endmodule : csa_peer

/* File: tb_top.sv */
`include "csa_defs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, jam, pol;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, sck, sck_oe_n, sdi, sdo, sdo_oe_n;
	logic        stb, stb_oe_n, busy, done, xck;
	int          n_fail = 0, total_checks = 0, cyc = 0;

	// Block under test; the external clock input idles high between bench-made pulses.
	csa_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .serial_clock_pin_in(xck),
		.serial_clock_pin_out(sck), .serial_clock_pin_oe_n(sck_oe_n),
		.serial_in_pin(sdi), .serial_out_pin(sdo), .serial_out_pin_oe_n(sdo_oe_n),
		.handshake_strobe_pin(stb), .handshake_strobe_pin_oe_n(stb_oe_n),
		.busy_pin(busy), .transfer_done_irq_flag(done));
	// Peripheral on the serial link.
	csa_peer peer_u (.pclk(pclk), .sck(sck), .sdo(sdo), .stb(stb), .jam(jam),
		.pol(pol), .sdi(sdi), .busy(busy));

	// Clock generation.
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// Compares one value and reports a mismatch.
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Ends the run with the verdict.
	task results;
		if (n_fail == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : results

	// One bus transfer: setup, then access held until ready.
	task apb(input logic w, input logic [15:0] idx, input logic [7:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) n_fail++;
	endtask : apb

	// Register write and checked register read.
	task wr(input logic [15:0] idx, input logic [7:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, idx, d, q, e);
	endtask : wr
	task rchk(input string what, input logic [15:0] idx, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		apb(1'b0, idx, 8'h00, q, e);
		check(what, q, exp);
	endtask : rchk

	// Waits for the done flag, then clears it.
	task wdone;
		int n;
		n = 0;
		while (done !== 1'b1 && n < 5000) begin
			@(posedge pclk);
			n++;
		end
		check("done flag", done, 32'h1);
		wr(`CSA_IDX_STATUS, 8'h01);
	endtask : wdone

	// Polls the active flag until the automatic sequence ends.
	task wtrf;
		logic [31:0] q;
		logic        e;
		int          n;
		n = 0;
		do begin
			apb(1'b0, `CSA_IDX_AUTO, 8'h00, q, e);
			n++;
		end while (q[3] !== 1'b0 && n < 2000);
		check("active flag", q & 32'h08, 32'h0);
	endtask : wtrf

	// Restarts the peripheral log with a new first reply byte.
	task pclr(input logic [7:0] t);
		peer_u.tx = t;
		peer_u.nbit = 0;
		peer_u.nrx = 0;
		peer_u.nstb = 0;
	endtask : pclr

	// Reset values, writable fields, idle pins and an unmapped address.
	task t_regs;
		logic [31:0] q;
		logic        e;
		rchk("mode reset", `CSA_IDX_MODE, 32'h0);
		rchk("auto reset", `CSA_IDX_AUTO, 32'h0);
		check("pins released", {sck_oe_n, sdo_oe_n, stb_oe_n}, 32'h7);
		wr(`CSA_IDX_MODE, 8'h7F);
		rchk("mode fields", `CSA_IDX_MODE, 32'h73);
		repeat (3) @(posedge pclk);
		check("clock held high", {sck_oe_n, sck}, 32'h1);
		wr(`CSA_IDX_MODE, 8'h00);
		repeat (3) @(posedge pclk);
		check("clock as port", sck_oe_n, 32'h1);
		wr(`CSA_IDX_AUTO, 8'hFF);
		rchk("auto fields", `CSA_IDX_AUTO, 32'hE7);
		wr(`CSA_IDX_AUTO, 8'h00);
		apb(1'b0, 16'hFF6B, 8'h00, q, e);
		check("unmapped error", e, 32'h1);
		check("unmapped data", q, 32'h0);
	endtask : t_regs

	// A shift write made before enabling must not start a transfer.
	task t_early;
		wr(`CSA_IDX_MODE, 8'h01);
		pclr(8'h00);
		wr(`CSA_IDX_SHIFT, 8'hA5);
		wr(`CSA_IDX_MODE, 8'h81);
		repeat (40) @(posedge pclk);
		check("no clocks", peer_u.nbit, 32'h0);
		check("no done", done, 32'h0);
	endtask : t_early

	// Plain bytes at each divider, then one byte least significant first.
	task t_plain;
		for (int s = 1; s < 4; s++) begin
			pclr(8'h3C);
			wr(`CSA_IDX_MODE, 8'h80 | 8'(s));
			wr(`CSA_IDX_SHIFT, 8'hA5);
			wdone();
			check("sent byte", peer_u.rxq[0], 32'hA5);
			check("half period", peer_u.half, 32'd4 << s);
			rchk("received byte", `CSA_IDX_SHIFT, 32'h3C);
		end
		check("clock driven", sck_oe_n, 32'h0);
		pclr(8'h00);
		wr(`CSA_IDX_MODE, 8'hC1);
		wr(`CSA_IDX_SHIFT, 8'h01);
		wdone();
		check("lsb first", peer_u.rxq[0], 32'h80);
	endtask : t_plain

	// Three bytes from the buffer with strobes, replies stored back.
	task t_auto;
		for (int i = 0; i < 3; i++) wr(`CSA_IDX_BUF_BASE + 16'(i), 8'h11 * 8'(i + 1));
		wr(`CSA_IDX_COUNT, 8'h02);
		wr(`CSA_IDX_AUTO, 8'h84);
		wr(`CSA_IDX_MODE, 8'hA1);
		pclr(8'h50);
		wr(`CSA_IDX_SHIFT, 8'h00);
		rchk("active set", `CSA_IDX_AUTO, 32'h8C);
		wtrf();
		wdone();
		check("auto count", peer_u.nrx, 32'h3);
		check("strobes", peer_u.nstb, 32'h3);
		for (int i = 0; i < 3; i++) begin
			check("auto sent", peer_u.rxq[i], 32'h11 * (i + 1));
			rchk("auto stored", `CSA_IDX_BUF_BASE + 16'(i), 32'h50 + i);
		end
	endtask : t_auto

	// Active-low busy held after each strobe; receive left off.
	task t_busy;
		pol <= 1'b1;
		peer_u.hold = 100;
		wr(`CSA_IDX_AUTO, 8'h07);
		wr(`CSA_IDX_COUNT, 8'h01);
		pclr(8'h00);
		wr(`CSA_IDX_SHIFT, 8'h00);
		wtrf();
		wdone();
		check("busy wait", peer_u.gap >= 100, 32'h1);
		check("busy count", peer_u.nrx, 32'h2);
		rchk("no receive", `CSA_IDX_BUF_BASE, 32'h50);
		peer_u.hold = 0;
		pol <= 1'b0;
	endtask : t_busy

	// Error check only with busy enabled; a shift write clears the error.
	task t_err;
		jam <= 1'b1;
		wr(`CSA_IDX_AUTO, 8'h20);
		wr(`CSA_IDX_SHIFT, 8'h00);
		wtrf();
		wdone();
		rchk("busy ignored", `CSA_IDX_AUTO, 32'h20);
		wr(`CSA_IDX_AUTO, 8'h22);
		wr(`CSA_IDX_SHIFT, 8'h00);
		wtrf();
		wdone();
		rchk("error set", `CSA_IDX_AUTO, 32'h32);
		jam <= 1'b0;
		wr(`CSA_IDX_SHIFT, 8'h00);
		rchk("error cleared", `CSA_IDX_AUTO, 32'h2A);
		wtrf();
		wdone();
	endtask : t_err

	// Repeat mode keeps running until the interface is disabled.
	task t_rpt;
		int n;
		wr(`CSA_IDX_AUTO, 8'h40);
		wr(`CSA_IDX_COUNT, 8'h00);
		pclr(8'h00);
		wr(`CSA_IDX_SHIFT, 8'h00);
		n = 0;
		while (peer_u.nrx < 3 && n < 2000) begin
			@(posedge pclk);
			n++;
		end
		rchk("repeat active", `CSA_IDX_AUTO, 32'h48);
		wr(`CSA_IDX_MODE, 8'h00);
		repeat (3) @(posedge pclk);
		check("output released", sdo_oe_n, 32'h1);
	endtask : t_rpt

	// External clock source: the bench clocks one plain byte and collects the output bits.
	task t_ext;
		logic [7:0] v;
		v = 8'h00;
		wr(`CSA_IDX_MODE, 8'h80);
		wr(`CSA_IDX_SHIFT, 8'hC3);
		check("clock as input", sck_oe_n, 32'h1);
		repeat (8) begin
			repeat (4) @(posedge pclk);
			xck <= 1'b0;
			repeat (4) @(posedge pclk);
			v = {v[6:0], sdo};
			xck <= 1'b1;
		end
		wdone();
		check("external sent", v, 32'hC3);
	endtask : t_ext

	// Main sequence.
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 18'h00000;
		pwdata = 32'h00000000;
		jam = 1'b0;
		pol = 1'b0;
		xck = 1'b1;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_early();
		t_plain();
		t_auto();
		t_busy();
		t_err();
		t_rpt();
		t_ext();
		results();
	end

	// Cuts a hang short.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			results();
		end
	end
endmodule : tb_top
